// >>> aes_pkg.sv
// package: register map, field layout and setup codes for the acpi event block
package aes_pkg;
    localparam logic [7:0]  OFS_FIXED_STS  = 8'h00;
    localparam logic [7:0]  OFS_FIXED_EN   = 8'h02;
    localparam logic [7:0]  OFS_PWR_CTL    = 8'h04;
    localparam logic [7:0]  OFS_CMD_PORT   = 8'h06;
    localparam logic [7:0]  OFS_SETUP_INDEX  = 8'h0E;
    localparam logic [7:0]  OFS_GP_STS     = 8'h10;
    localparam logic [7:0]  OFS_GP_EN      = 8'h12;
    localparam logic [7:0]  OFS_SETUP_VAL  = 8'h14;

    // fixed event status / enable bit positions
    localparam int FB_TMR    = 0;
    localparam int FB_GBL    = 5;
    localparam int FB_PWRBTN = 8;
    localparam int FB_SLPBTN = 9;
    localparam int FB_RTC    = 10;
    localparam int FB_WAKE   = 15;
    localparam logic [15:0] FIXED_EN_MASK = 16'h0721;

    // power control bit positions
    localparam int PC_SCI_EN  = 0;
    localparam int PC_GLOBAL_RELEASE = 2;
    localparam int PC_SLP_TYP_LO = 10;
    localparam int PC_SLEEP_ENTRY  = 13;
    localparam logic [15:0] PWR_CTL_MASK = 16'h1C05;

    localparam int TMR_CARRY_BIT = 23;

    // setup index codes
    localparam logic [7:0] IDX_NOP      = 8'h00;
    localparam logic [7:0] IDX_GPIO_LO  = 8'h10;
    localparam logic [7:0] IDX_GPIO_HI  = 8'h17;
    localparam logic [7:0] IDX_IRQ_LO   = 8'h30;
    localparam logic [7:0] IDX_IRQ_HI   = 8'h3F;
    localparam logic [7:0] IDX_IRQ_CASC = 8'h32;
    localparam logic [7:0] IDX_IRQ_FPU  = 8'h3D;
    localparam logic [7:0] IDX_GBL      = 8'h40;
    localparam logic [7:0] IDX_SCI_IRQ  = 8'h41;
    localparam logic [7:0] IDX_RD_EN    = 8'h42;
    localparam logic [7:0] IDX_ATOMIC   = 8'h43;
    localparam logic [7:0] IDX_VIDEO    = 8'h50;
    localparam logic [7:0] IDX_AUD_LO   = 8'h60;
    localparam logic [7:0] IDX_AUD_HI   = 8'h63;
    localparam logic [7:0] IDX_AUDIO    = 8'h64;

    // mapping data codes
    localparam logic [7:0] MAP_NONE   = 8'h00;
    localparam logic [7:0] MAP_PWRBTN = 8'h08;
    localparam logic [7:0] MAP_SLPBTN = 8'h09;
    localparam logic [7:0] MAP_RTC    = 8'h0A;
    localparam logic [7:0] MAP_GP_LO  = 8'h10;
    localparam logic [7:0] MAP_GP_HI  = 8'h1F;

    localparam logic [3:0] SCI_IRQ_DEFAULT = 4'h9;
    localparam logic [3:0] RTC_IRQ         = 4'h8;
    localparam int         GPIO_N = 8;
    localparam int         IRQ_N  = 16;

    // command port values switching delivery mode
    localparam logic [7:0] CMD_ACPI_ON  = 8'h01;
    localparam logic [7:0] CMD_ACPI_OFF = 8'h02;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } aes_bus_req_t;

    typedef struct packed {
        logic        gpio_set;
        logic        lid_set;
        logic        irq_set;
        logic [3:0]  target;
    } aes_evt_t;
endpackage : aes_pkg

// >>> aes_edge_det.sv
// edge detector for a vector of inputs with per-bit edge selection
`timescale 1ns/1ps
`default_nettype none
module aes_edge_det
    import aes_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input  wire logic             i_sys_clk,  // system clock
    input  wire logic             i_rst,      // sync reset
    input  wire logic [WIDTH-1:0] i_level,    // sampled levels
    input  wire logic [WIDTH-1:0] i_rise_en,  // detect rising edge
    input  wire logic [WIDTH-1:0] i_fall_en,  // detect falling edge
    output logic      [WIDTH-1:0] o_edge      // selected edge pulse
);
    if (WIDTH < 1)
    begin : gen_bad_width
        $error("aes_edge_det: WIDTH must be positive");
    end

    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] prev_nxt;

    always_comb prev_nxt = i_level;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            prev_r <= '0;
        else
            prev_r <= prev_nxt;
    end

    assign o_edge = (i_level & ~prev_r & i_rise_en) | (~i_level & prev_r & i_fall_en);
endmodule : aes_edge_det
`default_nettype wire

// >>> aes_map_decode.sv
// decodes a mapping code into one-hot fixed and general purpose targets
`timescale 1ns/1ps
`default_nettype none
module aes_map_decode
    import aes_pkg::*;
(
    input  wire logic [7:0]  i_code,      // mapping data code
    input  wire logic        i_hit,       // event present
    output logic      [15:0] o_fixed,     // fixed status set vector
    output logic      [15:0] o_gp         // gp status set vector
);
    always_comb
    begin
        o_fixed = '0;
        o_gp    = '0;
        if (i_hit)
        begin
            if (i_code == MAP_PWRBTN)
                o_fixed[FB_PWRBTN] = 1'b1;
            else if (i_code == MAP_SLPBTN)
                o_fixed[FB_SLPBTN] = 1'b1;
            else if (i_code == MAP_RTC)
                o_fixed[FB_RTC] = 1'b1;
            else if (i_code >= MAP_GP_LO && i_code <= MAP_GP_HI)
                o_gp[i_code[3:0]] = 1'b1;
        end
    end
endmodule : aes_map_decode
`default_nettype wire

// >>> aes_event_ctrl.sv
// acpi fixed and general purpose event status, enable, control and setup pair
`timescale 1ns/1ps
`default_nettype none
module aes_event_ctrl
    import aes_pkg::*;
#(
    parameter int N_GPIO = GPIO_N,
    parameter int N_IRQ  = IRQ_N
)(
    input  wire logic        i_sys_clk,      // system clock, 25 MHz
    input  wire logic        i_rst,          // sync reset, active high
    input  wire logic        i_io_wr,        // io write strobe, one cycle
    input  wire logic        i_io_rd,        // io read strobe, one cycle
    input  wire logic [7:0]  i_io_addr,      // byte offset from base
    input  wire logic [31:0] i_io_wdata,     // write data, low aligned
    output logic      [31:0] o_io_rdata,     // read data, registered
    output logic             o_io_rvalid,    // read data valid pulse
    input  wire logic [7:0]  i_gpio,         // gpio pin levels
    input  wire logic [15:0] i_irq,          // irq line levels
    input  wire logic        i_rtc_alarm,    // alarm event pulse
    input  wire logic [23:0] i_acpi_timer,   // free running timer count
    input  wire logic        i_sleeping,     // system in sleep state
    output logic             o_sci,          // system control interrupt
    output logic             o_smi,          // management interrupt
    output logic [3:0]       o_sci_irq,      // irq line for sci
    output logic             o_sleep_req,    // sleep entry pulse
    output logic [2:0]       o_sleep_type,   // sleep type with request
    output logic             o_gbl_release,  // firmware event pulse
    output logic             o_atomic_req,   // atomic sequence pulse
    output logic [31:0]      o_atomic_addr,  // atomic sequence address
    output logic             o_video_pwr,    // video power on
    output logic [1:0]       o_audio_pwr,    // audio power code
    output logic             o_audio_smi,    // audio soft smi pulse
    output logic [1:0]       o_audio_smi_sel,// audio soft smi number
    output logic [15:0]      o_audio_smi_val // audio soft smi value
);
    if (N_GPIO != GPIO_N || N_IRQ != IRQ_N)
    begin : gen_bad_size
        $error("aes_event_ctrl: only 8 gpio and 16 irq supported");
    end

    function automatic logic idx_valid(input logic [15:0] v);
        logic [7:0] b;
        b = v[7:0];
        idx_valid = (v[15:8] == 8'h00) &&
            ((b == IDX_NOP) || (b >= IDX_GPIO_LO && b <= IDX_GPIO_HI) ||
             (b >= IDX_IRQ_LO && b <= IDX_IRQ_HI) ||
             (b >= IDX_GBL && b <= IDX_ATOMIC) || (b == IDX_VIDEO) ||
             (b >= IDX_AUD_LO && b <= IDX_AUDIO));
    endfunction : idx_valid

    function automatic logic sci_line_ok(input logic [31:0] v);
        sci_line_ok = (v >= 32'h3 && v <= 32'h7) || (v >= 32'h9 && v <= 32'hC) ||
                      (v == 32'hE) || (v == 32'hF);
    endfunction : sci_line_ok

    function automatic logic map_ok(input logic [7:0] c);
        map_ok = (c == MAP_NONE) || (c == MAP_PWRBTN) || (c == MAP_SLPBTN) ||
                 (c >= MAP_GP_LO && c <= MAP_GP_HI);
    endfunction : map_ok

    logic [15:0] fsts_r, fsts_nxt;
    logic [15:0] fen_r, fen_nxt;
    logic [15:0] pctl_r, pctl_nxt;
    logic [15:0] gsts_r, gsts_nxt;
    logic [15:0] gen_r, gen_nxt;
    logic [15:0] sidx_r, sidx_nxt;
    logic [7:0]  gmap_r [GPIO_N];
    logic [7:0]  gmap_nxt [GPIO_N];
    logic [1:0]  gedge_r [GPIO_N];
    logic [1:0]  gedge_nxt [GPIO_N];
    logic [7:0]  imap_r [IRQ_N];
    logic [7:0]  imap_nxt [IRQ_N];
    logic [3:0]  sciq_r, sciq_nxt;
    logic        rden_r, rden_nxt;
    logic        tmr_prev_r;
    logic [31:0] rdata_r, rdata_nxt;
    logic        rvalid_r;
    logic        slp_r, slp_nxt;
    logic [2:0]  slpt_r, slpt_nxt;
    logic        rls_r, rls_nxt;
    logic        atom_r, atom_nxt;
    logic [31:0] aaddr_r, aaddr_nxt;
    logic        vid_r, vid_nxt;
    logic [1:0]  aud_r, aud_nxt;
    logic        asmi_r, asmi_nxt;
    logic [1:0]  asel_r, asel_nxt;
    logic [15:0] aval_r, aval_nxt;

    aes_bus_req_t req;
    assign req = '{wr: i_io_wr, rd: i_io_rd, addr: i_io_addr, wdata: i_io_wdata};

    logic [7:0]  rise_en, fall_en, gpio_edge;
    logic [15:0] irq_edge;
    logic [15:0] gset_fixed [GPIO_N];
    logic [15:0] gset_gp [GPIO_N];
    logic [15:0] iset_fixed [IRQ_N];
    logic [15:0] iset_gp [IRQ_N];

    always_comb
    begin
        for (int k = 0; k < GPIO_N; k++)
        begin
            rise_en[k] = gedge_r[k][1];
            fall_en[k] = gedge_r[k][0];
        end
    end

    aes_edge_det #(.WIDTH(GPIO_N)) u_gpio_edge (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_level   (i_gpio),
        .i_rise_en (rise_en),
        .i_fall_en (fall_en),
        .o_edge    (gpio_edge)
    );

    aes_edge_det #(.WIDTH(IRQ_N)) u_irq_edge (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_level   (i_irq),
        .i_rise_en ('1),
        .i_fall_en ('0),
        .o_edge    (irq_edge)
    );

    genvar g;
    generate
        for (g = 0; g < GPIO_N; g++)
        begin : gen_gmap
            aes_map_decode u_dec (
                .i_code  (gmap_r[g]),
                .i_hit   (gpio_edge[g]),
                .o_fixed (gset_fixed[g]),
                .o_gp    (gset_gp[g])
            );
        end
        for (g = 0; g < IRQ_N; g++)
        begin : gen_imap
            aes_map_decode u_dec (
                .i_code  (imap_r[g]),
                .i_hit   (irq_edge[g] & i_sleeping),
                .o_fixed (iset_fixed[g]),
                .o_gp    (iset_gp[g])
            );
        end
    endgenerate

    logic [15:0] fset, gset;
    logic        wake_evt;
    logic [7:0]  sidx_b;
    logic        sval_wr;
    logic [31:0] sval_rd;
    assign sidx_b  = sidx_r[7:0];
    assign sval_wr = req.wr && req.addr == OFS_SETUP_VAL;

    always_comb
    begin
        fset = '0;
        gset = '0;
        for (int k = 0; k < GPIO_N; k++)
        begin
            fset = fset | gset_fixed[k];
            gset = gset | gset_gp[k];
        end
        for (int k = 0; k < IRQ_N; k++)
        begin
            fset = fset | iset_fixed[k];
            gset = gset | iset_gp[k];
        end
        if (i_rtc_alarm)
            fset[FB_RTC] = 1'b1;
        if (i_acpi_timer[TMR_CARRY_BIT] != tmr_prev_r)
            fset[FB_TMR] = 1'b1;
        if (sval_wr && sidx_b == IDX_GBL)
            fset[FB_GBL] = 1'b1;
        wake_evt = i_sleeping &&
            (|(fset & fen_r & ~(16'h1 << FB_TMR)) || |(gset & gen_r));
        if (wake_evt)
            fset[FB_WAKE] = 1'b1;
    end

    // hardware set wins over a same-cycle write-one clear
    always_comb
    begin
        fsts_nxt = fsts_r;
        fen_nxt  = fen_r;
        pctl_nxt = pctl_r;
        gsts_nxt = gsts_r;
        gen_nxt  = gen_r;
        sidx_nxt = sidx_r;
        sciq_nxt = sciq_r;
        rden_nxt = rden_r;
        slp_nxt  = 1'b0;
        slpt_nxt = slpt_r;
        rls_nxt  = 1'b0;
        atom_nxt = 1'b0;
        aaddr_nxt = aaddr_r;
        vid_nxt  = vid_r;
        aud_nxt  = aud_r;
        asmi_nxt = 1'b0;
        asel_nxt = asel_r;
        aval_nxt = aval_r;
        for (int k = 0; k < GPIO_N; k++)
        begin
            gmap_nxt[k]  = gmap_r[k];
            gedge_nxt[k] = gedge_r[k];
        end
        for (int k = 0; k < IRQ_N; k++)
            imap_nxt[k] = imap_r[k];
        if (req.wr)
        begin
            unique case (req.addr)
                OFS_FIXED_STS: fsts_nxt = fsts_r & ~req.wdata[15:0];
                OFS_FIXED_EN:  fen_nxt  = req.wdata[15:0] & FIXED_EN_MASK;
                OFS_PWR_CTL:
                begin
                    pctl_nxt = req.wdata[15:0] & PWR_CTL_MASK;
                    pctl_nxt[PC_SCI_EN] = pctl_r[PC_SCI_EN];
                    if (req.wdata[PC_SLEEP_ENTRY])
                    begin
                        slp_nxt  = 1'b1;
                        slpt_nxt = req.wdata[PC_SLP_TYP_LO +: 3];
                    end
                    rls_nxt = req.wdata[PC_GLOBAL_RELEASE];
                end
                OFS_CMD_PORT:
                begin
                    if (req.wdata[7:0] == CMD_ACPI_ON)
                        pctl_nxt[PC_SCI_EN] = 1'b1;
                    else if (req.wdata[7:0] == CMD_ACPI_OFF)
                        pctl_nxt[PC_SCI_EN] = 1'b0;
                end
                OFS_SETUP_INDEX:
                    if (idx_valid(req.wdata[15:0]))
                        sidx_nxt = req.wdata[15:0];
                OFS_GP_STS:    gsts_nxt = gsts_r & ~req.wdata[15:0];
                OFS_GP_EN:     gen_nxt  = req.wdata[15:0];
                OFS_SETUP_VAL:
                begin
                    if (sidx_b >= IDX_GPIO_LO && sidx_b <= IDX_GPIO_HI &&
                        map_ok(req.wdata[7:0]))
                    begin
                        gmap_nxt[sidx_b[2:0]]  = req.wdata[7:0];
                        gedge_nxt[sidx_b[2:0]] = req.wdata[9:8];
                    end
                    else if (sidx_b >= IDX_IRQ_LO && sidx_b <= IDX_IRQ_HI &&
                             sidx_b != IDX_IRQ_CASC && sidx_b != IDX_IRQ_FPU)
                        imap_nxt[sidx_b[3:0]] = req.wdata[7:0];
                    else if (sidx_b == IDX_SCI_IRQ && sci_line_ok(req.wdata))
                        sciq_nxt = req.wdata[3:0];
                    else if (sidx_b == IDX_RD_EN)
                        rden_nxt = 1'b1;
                    else if (sidx_b == IDX_ATOMIC)
                    begin
                        atom_nxt  = 1'b1;
                        aaddr_nxt = req.wdata;
                    end
                    else if (sidx_b == IDX_VIDEO)
                        vid_nxt = req.wdata[0];
                    else if (sidx_b >= IDX_AUD_LO && sidx_b <= IDX_AUD_HI)
                    begin
                        asmi_nxt = 1'b1;
                        asel_nxt = sidx_b[1:0];
                        aval_nxt = req.wdata[15:0];
                    end
                    else if (sidx_b == IDX_AUDIO)
                        aud_nxt = req.wdata[1:0];
                end
                default: ;
            endcase
        end
        fsts_nxt = fsts_nxt | fset;
        gsts_nxt = gsts_nxt | gset;
    end

    // index hold persists for a read of the mapping tables
    always_comb
    begin
        sval_rd = '0;
        if (sidx_b >= IDX_GPIO_LO && sidx_b <= IDX_GPIO_HI)
            sval_rd = {22'h0, gedge_r[sidx_b[2:0]], gmap_r[sidx_b[2:0]]};
        else if (sidx_b >= IDX_IRQ_LO && sidx_b <= IDX_IRQ_HI)
            sval_rd = {24'h0, imap_r[sidx_b[3:0]]};
        else if (sidx_b == IDX_SCI_IRQ)
            sval_rd = {28'h0, sciq_r};
        else if (sidx_b == IDX_ATOMIC)
            sval_rd = aaddr_r;
        else if (sidx_b == IDX_VIDEO)
            sval_rd = {31'h0, vid_r};
        else if (sidx_b == IDX_AUDIO)
            sval_rd = {30'h0, aud_r};
    end

    always_comb
    begin
        rdata_nxt = '0;
        if (req.rd && rden_r)
        begin
            unique case (req.addr)
                OFS_FIXED_STS: rdata_nxt = {16'h0, fsts_r};
                OFS_FIXED_EN:  rdata_nxt = {16'h0, fen_r};
                OFS_PWR_CTL:   rdata_nxt = {16'h0, pctl_r};
                OFS_SETUP_INDEX: rdata_nxt = {16'h0, sidx_r};
                OFS_GP_STS:    rdata_nxt = {16'h0, gsts_r};
                OFS_GP_EN:     rdata_nxt = {16'h0, gen_r};
                OFS_SETUP_VAL: rdata_nxt = sval_rd;
                default:       rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            fsts_r <= '0;
            fen_r  <= '0;
            pctl_r <= '0;
            gsts_r <= '0;
            gen_r  <= '0;
            sidx_r <= '0;
            sciq_r <= SCI_IRQ_DEFAULT;
            rden_r <= 1'b0;
            tmr_prev_r <= 1'b0;
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
            slp_r  <= 1'b0;
            slpt_r <= '0;
            rls_r  <= 1'b0;
            atom_r <= 1'b0;
            aaddr_r <= '0;
            vid_r  <= 1'b1;
            aud_r  <= '0;
            asmi_r <= 1'b0;
            asel_r <= '0;
            aval_r <= '0;
            for (int k = 0; k < GPIO_N; k++)
            begin
                gmap_r[k]  <= MAP_NONE;
                gedge_r[k] <= '0;
            end
            for (int k = 0; k < IRQ_N; k++)
                imap_r[k] <= (k == int'(RTC_IRQ)) ? MAP_RTC : MAP_NONE;
        end
        else
        begin
            fsts_r <= fsts_nxt;
            fen_r  <= fen_nxt;
            pctl_r <= pctl_nxt;
            gsts_r <= gsts_nxt;
            gen_r  <= gen_nxt;
            sidx_r <= sidx_nxt;
            sciq_r <= sciq_nxt;
            rden_r <= rden_nxt;
            // timer reset value has bit 23 low, so zero start is consistent
            tmr_prev_r <= i_acpi_timer[TMR_CARRY_BIT];
            rdata_r  <= rdata_nxt;
            rvalid_r <= req.rd;
            slp_r  <= slp_nxt;
            slpt_r <= slpt_nxt;
            rls_r  <= rls_nxt;
            atom_r <= atom_nxt;
            aaddr_r <= aaddr_nxt;
            vid_r  <= vid_nxt;
            aud_r  <= aud_nxt;
            asmi_r <= asmi_nxt;
            asel_r <= asel_nxt;
            aval_r <= aval_nxt;
            for (int k = 0; k < GPIO_N; k++)
            begin
                gmap_r[k]  <= gmap_nxt[k];
                gedge_r[k] <= gedge_nxt[k];
            end
            for (int k = 0; k < IRQ_N; k++)
                imap_r[k] <= imap_nxt[k];
        end
    end

    logic pending;
    assign pending = |(fsts_r & fen_r) | |(gsts_r & gen_r);
    assign o_sci   = pending & pctl_r[PC_SCI_EN];
    assign o_smi   = pending & ~pctl_r[PC_SCI_EN];
    assign o_sci_irq     = sciq_r;
    assign o_io_rdata    = rdata_r;
    assign o_io_rvalid   = rvalid_r;
    assign o_sleep_req   = slp_r;
    assign o_sleep_type  = slpt_r;
    assign o_gbl_release = rls_r;
    assign o_atomic_req  = atom_r;
    assign o_atomic_addr = aaddr_r;
    assign o_video_pwr   = vid_r;
    assign o_audio_pwr   = aud_r;
    assign o_audio_smi   = asmi_r;
    assign o_audio_smi_sel = asel_r;
    assign o_audio_smi_val = aval_r;
endmodule : aes_event_ctrl
`default_nettype wire

// >>> aes_event_ctrl_chk.sv
// checker: port-level timing rules of the acpi event block
`timescale 1ns/1ps
`default_nettype none
module aes_event_ctrl_chk
    import aes_pkg::*;
(
    input wire logic        i_sys_clk,    // clock
    input wire logic        i_rst,        // reset
    input wire logic        i_io_wr,      // write strobe
    input wire logic        i_io_rd,      // read strobe
    input wire logic [7:0]  i_io_addr,    // offset
    input wire logic [31:0] i_io_wdata,   // write data
    input wire logic [31:0] o_io_rdata,   // read data
    input wire logic        o_io_rvalid,  // read valid
    input wire logic        o_sci,        // sci
    input wire logic        o_smi,        // smi
    input wire logic [3:0]  o_sci_irq,    // sci line
    input wire logic        o_sleep_req,  // sleep pulse
    input wire logic [2:0]  o_sleep_type  // sleep type
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire slp_wr = i_io_wr && i_io_addr == OFS_PWR_CTL && i_io_wdata[PC_SLEEP_ENTRY];
    wire acpi_on = i_io_wr && i_io_addr == OFS_CMD_PORT && i_io_wdata[7:0] == CMD_ACPI_ON;
    sequence s_slp;
        slp_wr;
    endsequence
    AST_RD_LAT: assert property (i_io_rd |=> o_io_rvalid)
        else $error("read not answered");
    AST_RV_ONLY: assert property (!i_io_rd |=> !o_io_rvalid)
        else $error("stray read valid");
    AST_RD_IDLE: assert property (!o_io_rvalid |-> o_io_rdata == 32'h0)
        else $error("read data not idle");
    AST_SLEEP: assert property (s_slp |=> o_sleep_req &&
        o_sleep_type == $past(i_io_wdata[PC_SLP_TYP_LO +: 3]))
        else $error("sleep request wrong");
    AST_NO_SLEEP: assert property (!slp_wr |=> !o_sleep_req)
        else $error("stray sleep request");
    AST_EXCL: assert property (!(o_sci && o_smi))
        else $error("both interrupts active");
    AST_SCI_MODE: assert property (acpi_on |=> !o_smi)
        else $error("management interrupt after delivery switch");
    AST_IRQ_OK: assert property (o_sci_irq inside {[3:7], [9:12], 14, 15})
        else $error("illegal sci line");
    AST_IRQ_RST: assert property ($past(i_rst) |-> o_sci_irq == SCI_IRQ_DEFAULT)
        else $error("sci line reset wrong");
    AST_IRQ_HOLD: assert property (!(i_io_wr && i_io_addr == OFS_SETUP_VAL) |=> $stable(o_sci_irq))
        else $error("sci line moved");
endmodule : aes_event_ctrl_chk
bind aes_event_ctrl aes_event_ctrl_chk aes_event_ctrl_chk_i (.i_sys_clk, .i_rst, .i_io_wr,
    .i_io_rd, .i_io_addr, .i_io_wdata, .o_io_rdata, .o_io_rvalid, .o_sci, .o_smi, .o_sci_irq,
    .o_sleep_req, .o_sleep_type);
`default_nettype wire

// >>> aes_event_ctrl_test.sv
// testbench: register and event scenarios of the acpi event block
`timescale 1ns/1ps
`default_nettype none
module aes_event_ctrl_test
    import aes_pkg::*;
;
    logic        sys_clk = 0;
    logic        rst = 1;
    logic        io_wr = 0;
    logic        io_rd = 0;
    logic [7:0]  io_addr = 8'h00;
    logic [31:0] io_wdata = 32'h0;
    logic [31:0] seed = 32'h72DB1249;
    logic [7:0]  gpio = 8'h00;
    logic [23:0] timer = 24'h0;
    logic        sleeping = 0;
    logic        rtc = 0;
    logic [15:0] irq = 16'h0;
    logic        slp_req, rls, atom, vid, asmi;
    logic [2:0]  slp_t;
    logic [31:0] aaddr;
    logic [1:0]  aud, asel;
    logic [15:0] aval;
    logic [31:0] io_rdata;
    logic        io_rvalid, sci, smi;
    logic [3:0]  sci_irq;
    int          mismatches = 0;
    int          n_compared = 0;
    always #20 sys_clk = ~sys_clk;
    aes_event_ctrl aes_event_ctrl_i (.i_sys_clk(sys_clk), .i_rst(rst), .i_io_wr(io_wr),
        .i_io_rd(io_rd), .i_io_addr(io_addr), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
        .o_io_rvalid(io_rvalid), .i_gpio(gpio), .i_irq(irq), .i_rtc_alarm(rtc),
        .i_acpi_timer(timer), .i_sleeping(sleeping), .o_sci(sci), .o_smi(smi),
        .o_sci_irq(sci_irq), .o_sleep_req(slp_req), .o_sleep_type(slp_t),
        .o_gbl_release(rls), .o_atomic_req(atom), .o_atomic_addr(aaddr), .o_video_pwr(vid),
        .o_audio_pwr(aud), .o_audio_smi(asmi), .o_audio_smi_sel(asel), .o_audio_smi_val(aval));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge sys_clk);
        io_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge sys_clk);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        #1 chk(nm, io_rdata, exp);
    endtask : rd
    task automatic print_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #100000;
        mismatches++;
        print_verdict;
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        wr(OFS_GP_EN, 32'h0040);
        chk("video_reset", {31'h0, vid}, 32'h1);
        rd(OFS_GP_EN, 32'h0, "read_locked");
        wr(OFS_SETUP_INDEX, {24'h0, IDX_RD_EN});
        wr(OFS_SETUP_VAL, 32'h0);
        rd(OFS_GP_EN, 32'h0040, "gp_enable");
        repeat (4)
        begin
            seed = lfsr(seed);
            wr(OFS_FIXED_EN, seed);
            rd(OFS_FIXED_EN, seed & {16'h0, FIXED_EN_MASK}, "fixed_enable");
        end
        wr(OFS_FIXED_EN, {16'h0, FIXED_EN_MASK});
        wr(OFS_SETUP_INDEX, 32'h0016);
        wr(OFS_SETUP_INDEX, 32'h0099);
        rd(OFS_SETUP_INDEX, 32'h0016, "setup_index");
        wr(OFS_SETUP_VAL, 32'h0316);
        rd(OFS_SETUP_VAL, 32'h0316, "gpio6_map");
        @(posedge sys_clk) gpio <= 8'h40;
        repeat (4) @(posedge sys_clk);
        rd(OFS_GP_STS, 32'h0040, "lid_rise");
        chk("smi_mode", {31'h0, smi}, 32'h1);
        wr(OFS_CMD_PORT, {24'h0, CMD_ACPI_ON});
        chk("sci_mode", {31'h0, sci}, 32'h1);
        wr(OFS_GP_STS, 32'h0040);
        rd(OFS_GP_STS, 32'h0, "gp_clear");
        chk("sci_clear", {31'h0, sci}, 32'h0);
        @(posedge sys_clk) gpio <= 8'h00;
        repeat (4) @(posedge sys_clk);
        rd(OFS_GP_STS, 32'h0040, "lid_fall");
        wr(OFS_GP_EN, 32'h0);
        chk("sci_masked", {31'h0, sci}, 32'h0);
        wr(OFS_SETUP_INDEX, {24'h0, IDX_GPIO_LO});
        wr(OFS_SETUP_VAL, {22'h0, 2'b10, MAP_PWRBTN});
        @(posedge sys_clk) gpio <= 8'h01;
        timer <= 24'h800000;
        repeat (4) @(posedge sys_clk);
        wr(OFS_SETUP_INDEX, {24'h0, IDX_GBL});
        wr(OFS_SETUP_VAL, 32'h1);
        rd(OFS_FIXED_STS, 32'h0121, "fixed_status");
        chk("sci_fixed", {31'h0, sci}, 32'h1);
        wr(OFS_SETUP_INDEX, {24'h0, IDX_SCI_IRQ});
        wr(OFS_SETUP_VAL, 32'h8);
        chk("sci_line_bad", {28'h0, sci_irq}, 32'h9);
        wr(OFS_SETUP_VAL, 32'h5);
        chk("sci_line", {28'h0, sci_irq}, 32'h5);
        wr(OFS_PWR_CTL, 32'h2C05);
        chk("sleep_release", {27'h0, slp_req, slp_t, rls}, 32'h17);
        wr(OFS_FIXED_STS, 32'hFFFF);
        wr(OFS_GP_STS, 32'hFFFF);
        wr(OFS_SETUP_INDEX, 32'h0011);
        wr(OFS_SETUP_VAL, {22'h0, 2'b10, MAP_SLPBTN});
        wr(OFS_SETUP_INDEX, 32'h0033);
        wr(OFS_SETUP_VAL, 32'h0012);
        @(posedge sys_clk) sleeping <= 1'b1;
        irq <= 16'h0108;
        gpio <= 8'h03;
        rd(OFS_FIXED_STS, 32'h8600, "wake_fixed");
        rd(OFS_GP_STS, 32'h0004, "irq_wake");
        wr(OFS_FIXED_STS, 32'hFFFF);
        @(posedge sys_clk) rtc <= 1'b1;
        @(posedge sys_clk) rtc <= 1'b0;
        rd(OFS_FIXED_STS, 32'h8400, "alarm_wake");
        wr(OFS_SETUP_INDEX, {24'h0, IDX_NOP});
        rd(OFS_SETUP_VAL, 32'h0, "index_nop");
        wr(OFS_SETUP_INDEX, {24'h0, IDX_ATOMIC});
        seed = lfsr(seed);
        wr(OFS_SETUP_VAL, seed);
        chk("atomic_req", {31'h0, atom}, 32'h1);
        chk("atomic_addr", aaddr, seed);
        wr(OFS_SETUP_INDEX, {24'h0, IDX_VIDEO});
        wr(OFS_SETUP_VAL, 32'h0);
        chk("video_off", {31'h0, vid}, 32'h0);
        wr(OFS_SETUP_INDEX, 32'h0061);
        wr(OFS_SETUP_VAL, 32'h1234ABCD);
        chk("audio_smi", {13'h0, asmi, asel, aval}, 32'h0005ABCD);
        wr(OFS_SETUP_INDEX, {24'h0, IDX_AUDIO});
        wr(OFS_SETUP_VAL, 32'h2);
        chk("audio_power", {30'h0, aud}, 32'h2);
        print_verdict;
    end
endmodule : aes_event_ctrl_test
`default_nettype wire
